// ---- orp_regs.vh ----
/*
  Constants of the overlay region engine: header word indices, field positions,
  mixing and filter codes and the alpha, gain and address figures.
  Assumes a 32-bit descriptor word and bitfield positions fixed in this file.
*/
`ifndef ORP_REGS_VH
`define ORP_REGS_VH
// Header layout
`define ORP_HDR_WORDS 9
`define ORP_HDR_LAST 4'h8
`define ORP_WD_CTRL 0
`define ORP_WD_LUT 1
`define ORP_WD_TOTAL 2
`define ORP_WD_XL 3
`define ORP_WD_XR 4
`define ORP_WD_BOT 5
`define ORP_WD_TOP 6
`define ORP_WD_PAL 7
`define ORP_WD_NEXT 8
// Word 0 fields
`define ORP_PPL_LSB 0
`define ORP_GAIN_LSB 12
`define ORP_GAINEN_BIT 18
`define ORP_MODE_LSB 19
`define ORP_FILT_LSB 21
`define ORP_FRESH_BIT 23
`define ORP_STOP_BIT 24
// Word 1 fields
`define ORP_LIDX_LSB 0
`define ORP_LCNT_LSB 8
`define ORP_STRIDE_LSB 16
// Word 2 fields
`define ORP_TOTAL_LSB 0
`define ORP_OFFS_LSB 22
// Words 3 and 4 fields
`define ORP_X_LSB 0
`define ORP_Y_LSB 12
`define ORP_WEIGHT_LSB 24
`define ORP_BGAIN_LSB 23
// Mixing modes
`define ORP_MIX_PIXEL 2'h0
`define ORP_MIX_GLOBAL 2'h1
`define ORP_MIX_PROP 2'h2
`define ORP_MIX_NONE 2'h3
// Filter modes
`define ORP_FILT_NONE 2'h0
`define ORP_FILT_FLICKER 2'h1
`define ORP_FILT_FLUTTER 2'h2
// Alpha, gain and address figures
`define ORP_ALPHA_FULL 8'h80
`define ORP_GAIN_SHIFT 5
`define ORP_MIX_SHIFT 7
`define ORP_ADDR_STEP 32'h00000004
`endif

// ---- orp_gain_offset.v ----
/*
  Gain and offset stage for one 10-bit colour component.
  Assumes a combinational slot between the look-up and the blend.
*/
`timescale 1ns/1ps
`include "orp_regs.vh"
module orp_gain_offset (
  // Control
  input wire enable,
  input wire [5:0] gain,
  input wire [9:0] offset,
  // Data
  input wire [9:0] comp_in,
  output reg [9:0] comp_out
);
  reg [15:0] prod;
  reg [11:0] sum;
  // Factor is gain/32, then the offset; result saturates at full scale
  always @*
  begin
    prod = gain * comp_in;
    sum = {1'b0, prod[15:`ORP_GAIN_SHIFT]} + {2'h0, offset};
    if (!enable)
      comp_out = comp_in;
    else if (sum[11:10] != 2'h0)
      comp_out = 10'h3FF;
    else
      comp_out = sum[9:0];
  end
endmodule

// ---- orp_buf2.v ----
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock; in_ready and out_valid are registered so a stall loses no word.
*/
`timescale 1ns/1ps
module orp_buf2 #(
  parameter W = 30
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Fill side
  input wire in_valid,
  input wire [W-1:0] in_data,
  output reg in_ready,
  // Drain side
  output reg out_valid,
  output reg [W-1:0] out_data,
  input wire out_ready
);
  reg [W-1:0] spare;
  reg [1:0] count;
  reg [1:0] next_count;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  // Occupancy after this edge
  always @*
  begin
    next_count = count;
    if (push & ~pop)
      next_count = count + 2'h1;
    else if (pop & ~push)
      next_count = count - 2'h1;
  end
  // Head word sits in out_data, second word in spare
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count <= 2'h0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
      out_data <= {W{1'b0}};
      spare <= {W{1'b0}};
    end
    else
    begin
      count <= next_count;
      in_ready <= (next_count != 2'h2);
      out_valid <= (next_count != 2'h0);
      if (pop)
      begin
        if (push && count == 2'h1)
          out_data <= in_data;
        else
          out_data <= spare;
        if (push && count == 2'h2)
          spare <= in_data;
      end
      else if (push)
      begin
        if (count == 2'h0)
          out_data <= in_data;
        else
          spare <= in_data;
      end
    end
  end
endmodule

// ---- orp_region_engine.v ----
/*
  Overlay region engine: fetches region headers and palettes from memory,
  follows the descriptor chain, and colours, filters, scales and blends pixels.
  Assumes memory, timing and pixel-index sources all run on clk_sys.
*/
`timescale 1ns/1ps
`include "orp_regs.vh"
module orp_region_engine (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Global configuration
  input wire overlay_enable,
  input wire [31:0] first_descriptor_addr,
  input wire edge_smoothing_disable,
  input wire [7:0] edge_smoothing_value,
  // Memory read port
  output reg mem_rd_req,
  output reg [31:0] mem_rd_addr,
  input wire mem_rd_valid,
  input wire [31:0] mem_rd_data,
  // Display timing
  input wire frame_start,
  input wire line_start,
  input wire [10:0] line_number,
  input wire field_bottom,
  // Bitmap line address for the pixel fetcher
  output reg [31:0] bitmap_line_addr,
  // Pixel input: table index, position and video behind it
  input wire pix_valid,
  output wire pix_ready,
  input wire [7:0] pix_index,
  input wire [11:0] pix_x,
  input wire [29:0] pix_video,
  // Blended pixel output
  output wire out_valid,
  input wire out_ready,
  output wire [29:0] out_rgb,
  // Status
  output reg overlay_on,
  output reg region_active
);
  localparam S_IDLE = 5'h01;
  localparam S_HDR = 5'h02;
  localparam S_LUT = 5'h04;
  localparam S_SHOW = 5'h08;
  localparam S_OFF = 5'h10;

  reg [4:0] state;
  reg [8:0] word_cnt;
  reg [7:0] load_idx;
  reg [31:0] hdr [0:`ORP_HDR_WORDS-1];
  reg [31:0] lut [0:255];
  reg [31:0] prev_line [0:4095];
  reg first_line;
  reg last_line;
  reg prev_ok;
  reg [12:0] line_pix_cnt;
  reg [21:0] field_cnt;
  integer i;

  // Header fields
  wire [31:0] w_ctrl = hdr[`ORP_WD_CTRL];
  wire [31:0] w_lut = hdr[`ORP_WD_LUT];
  wire [11:0] pixels_per_line = w_ctrl[`ORP_PPL_LSB +: 12];
  wire [5:0] gain = w_ctrl[`ORP_GAIN_LSB +: 6];
  wire gain_enable_flag = w_ctrl[`ORP_GAINEN_BIT];
  wire [1:0] blend_mode_select = w_ctrl[`ORP_MODE_LSB +: 2];
  wire [1:0] vertical_filter_select = w_ctrl[`ORP_FILT_LSB +: 2];
  wire fresh_palette_flag = w_ctrl[`ORP_FRESH_BIT];
  wire stop_chain_flag = w_ctrl[`ORP_STOP_BIT];
  wire [7:0] lut_load_index = w_lut[`ORP_LIDX_LSB +: 8];
  wire [7:0] color_load_count = w_lut[`ORP_LCNT_LSB +: 8];
  wire [12:0] line_stride = w_lut[`ORP_STRIDE_LSB +: 13];
  wire [21:0] field_pixel_total = hdr[`ORP_WD_TOTAL][`ORP_TOTAL_LSB +: 22];
  wire [9:0] offset = hdr[`ORP_WD_TOTAL][`ORP_OFFS_LSB +: 10];
  wire [11:0] x_left = hdr[`ORP_WD_XL][`ORP_X_LSB +: 12];
  wire [10:0] y_bottom = hdr[`ORP_WD_XL][`ORP_Y_LSB +: 11];
  wire [7:0] region_blend_weight = hdr[`ORP_WD_XL][`ORP_WEIGHT_LSB +: 8];
  wire [11:0] x_right = hdr[`ORP_WD_XR][`ORP_X_LSB +: 12];
  wire [10:0] y_top = hdr[`ORP_WD_XR][`ORP_Y_LSB +: 11];
  wire [8:0] blend_gain_factor = hdr[`ORP_WD_XR][`ORP_BGAIN_LSB +: 9];
  wire [31:0] next_descriptor_pointer = hdr[`ORP_WD_NEXT];

  wire in_region = (line_number >= y_top) && (line_number <= y_bottom);

  // Descriptor chain and palette load sequencer
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= S_IDLE;
      mem_rd_req <= 1'b0;
      mem_rd_addr <= 32'h00000000;
      word_cnt <= 9'h000;
      load_idx <= 8'h00;
      overlay_on <= 1'b0;
    end
    else if (!overlay_enable)
    begin
      state <= S_IDLE;
      mem_rd_req <= 1'b0;
      overlay_on <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE, S_OFF, S_SHOW:
        begin
          if (frame_start)
          begin
            // Each field walks the chain afresh from its first descriptor
            state <= S_HDR;
            mem_rd_req <= 1'b1;
            mem_rd_addr <= first_descriptor_addr;
            word_cnt <= 9'h000;
            overlay_on <= 1'b1;
          end
          else if (state == S_SHOW && line_start && line_number > y_bottom)
          begin
            if (stop_chain_flag)
            begin
              state <= S_OFF;
              overlay_on <= 1'b0;
            end
            else
            begin
              state <= S_HDR;
              mem_rd_req <= 1'b1;
              mem_rd_addr <= next_descriptor_pointer;
              word_cnt <= 9'h000;
            end
          end
        end
        S_HDR:
        begin
          if (mem_rd_valid)
          begin
            mem_rd_addr <= mem_rd_addr + `ORP_ADDR_STEP;
            word_cnt <= word_cnt + 9'h001;
            if (word_cnt[3:0] == `ORP_HDR_LAST)
            begin
              word_cnt <= 9'h000;
              if (fresh_palette_flag)
              begin
                state <= S_LUT;
                mem_rd_addr <= hdr[`ORP_WD_PAL];
                load_idx <= lut_load_index;
              end
              else
              begin
                state <= S_SHOW;
                mem_rd_req <= 1'b0;
              end
            end
          end
        end
        S_LUT:
        begin
          if (mem_rd_valid)
          begin
            mem_rd_addr <= mem_rd_addr + `ORP_ADDR_STEP;
            load_idx <= load_idx + 8'h01;
            word_cnt <= word_cnt + 9'h001;
            if (word_cnt == {1'b0, color_load_count})
            begin
              state <= S_SHOW;
              mem_rd_req <= 1'b0;
            end
          end
        end
        default:
        begin
          state <= S_IDLE;
          mem_rd_req <= 1'b0;
        end
      endcase
    end
  end

  // Header words land in order; held in reset so fields are defined
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (i = 0; i < `ORP_HDR_WORDS; i = i + 1)
        hdr[i] <= 32'h00000000;
    end
    else if (state == S_HDR && mem_rd_valid)
      hdr[word_cnt[3:0]] <= mem_rd_data;
  end

  // Palette table write, wrapping at the top entry
  always @(posedge clk_sys)
  begin
    if (state == S_LUT && mem_rd_valid)
      lut[load_idx] <= mem_rd_data;
  end

  // Pixel accept and show qualifiers; the line counters below need them,
  // so they are declared ahead of both users
  wire pix_go = pix_valid & pix_ready;
  wire shown = (state == S_SHOW) && region_active && (pix_x >= x_left) && (pix_x <= x_right)
    && (line_pix_cnt < {1'b0, pixels_per_line})
    && (line_pix_cnt < line_stride)
    && (field_cnt < field_pixel_total);

  // Line tracking and the bitmap line pointer
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bitmap_line_addr <= 32'h00000000;
      region_active <= 1'b0;
      first_line <= 1'b0;
      last_line <= 1'b0;
      prev_ok <= 1'b0;
      line_pix_cnt <= 13'h0000;
      field_cnt <= 22'h000000;
    end
    else
    begin
      if (line_start)
      begin
        region_active <= (state == S_SHOW) && in_region;
        first_line <= (line_number == y_top);
        last_line <= (line_number == y_bottom);
        prev_ok <= (line_number > y_top);
        line_pix_cnt <= 13'h0000;
        if (line_number == y_top)
        begin
          field_cnt <= 22'h000000;
          bitmap_line_addr <= field_bottom ? hdr[`ORP_WD_BOT] : hdr[`ORP_WD_TOP];
        end
        else if (in_region)
          bitmap_line_addr <= bitmap_line_addr + {19'h00000, line_stride};
      end
      else if (pix_go && shown)
      begin
        line_pix_cnt <= line_pix_cnt + 13'h0001;
        field_cnt <= field_cnt + 22'h000001;
      end
    end
  end

  // Pixel path
  wire [31:0] lut_word = lut[pix_index];
  wire [31:0] prv_word = prev_line[pix_x];
  wire [31:0] filt;

  // Remember this line's table values for the next line's vertical filter
  always @(posedge clk_sys)
  begin
    if (pix_go && shown)
      prev_line[pix_x] <= lut_word;
  end

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1)
    begin : g_filt
      wire [7:0] cur = lut_word[8*k +: 8];
      wire [7:0] prv = prv_word[8*k +: 8];
      wire [8:0] half = {1'b0, cur} + {1'b0, prv};
      wire [9:0] quart = {2'h0, cur} + {1'b0, cur, 1'b0} + {2'h0, prv};
      // Top line has no line above it, so it passes unfiltered
      assign filt[8*k +: 8] = !prev_ok ? cur :
        (vertical_filter_select == `ORP_FILT_FLICKER) ? half[8:1] :
        (vertical_filter_select == `ORP_FILT_FLUTTER) ? quart[9:2] : cur;
    end
  endgenerate

  // Mixing factor; alpha path never sees the colour gain
  reg [7:0] a_sat;
  reg [7:0] a_edge;
  reg [7:0] e_sat;
  reg [7:0] factor;
  reg [15:0] a_prod;
  reg [15:0] e_prod;
  reg [14:0] a_div;
  always @*
  begin
    a_sat = (filt[7:0] > `ORP_ALPHA_FULL) ? `ORP_ALPHA_FULL : filt[7:0];
    e_sat = (edge_smoothing_value > `ORP_ALPHA_FULL) ? `ORP_ALPHA_FULL : edge_smoothing_value;
    e_prod = a_sat * e_sat;
    a_edge = a_sat;
    if (!edge_smoothing_disable && (first_line || last_line))
      a_edge = e_prod[14:7];
    a_prod = a_edge * blend_gain_factor[7:0];
    a_div = (blend_gain_factor[7:0] == 8'h00) ? 15'h7FFF :
      {a_edge, 7'h00} / {7'h00, blend_gain_factor[7:0]};
    case (blend_mode_select)
      `ORP_MIX_PIXEL:
        factor = a_edge;
      `ORP_MIX_GLOBAL:
        factor = (region_blend_weight > `ORP_ALPHA_FULL) ? `ORP_ALPHA_FULL :
          region_blend_weight;
      `ORP_MIX_PROP:
        if (blend_gain_factor[8])
          factor = (a_prod > 16'h0080) ? `ORP_ALPHA_FULL : a_prod[7:0];
        else
          factor = (a_div > 15'h0080) ? `ORP_ALPHA_FULL : a_div[7:0];
      default:
        factor = `ORP_ALPHA_FULL;
    endcase
    if (!shown)
      factor = 8'h00;
  end

  // Per-component gain, offset and blend
  wire [29:0] mixed;
  wire [8:0] inv_factor = 9'h080 - {1'b0, factor};
  generate
    for (k = 0; k < 3; k = k + 1)
    begin : g_mix
      wire [7:0] c8 = filt[8*(k+1) +: 8];
      wire [9:0] c10;
      wire [9:0] v10 = pix_video[10*k +: 10];
      wire [18:0] sum;
      orp_gain_offset u_gain (
        .enable(gain_enable_flag),
        .gain(gain),
        .offset(offset),
        .comp_in({c8, c8[7:6]}),
        .comp_out(c10)
      );
      assign sum = ({1'b0, factor} * c10) + (inv_factor * v10);
      assign mixed[10*k +: 10] = sum[16:7];
    end
  endgenerate

  // Output buffer absorbs a stall by the compositor
  orp_buf2 #(
    .W(30)
  ) u_buf (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .in_valid(pix_valid),
    .in_data(mixed),
    .in_ready(pix_ready),
    .out_valid(out_valid),
    .out_data(out_rgb),
    .out_ready(out_ready)
  );
endmodule

// ---- orp_props.sv ----
/*
  Port checker of the overlay region engine.
  Assumes one clock domain and is bound to orp_region_engine below.
*/
`timescale 1ns/1ps
module orp_props (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Control and timing
  input wire overlay_enable,
  input wire frame_start,
  input wire line_start,
  // Memory port
  input wire mem_rd_req,
  input wire [31:0] mem_rd_addr,
  input wire mem_rd_valid,
  // Pixel path
  input wire pix_valid,
  input wire pix_ready,
  input wire out_valid,
  input wire out_ready,
  input wire [29:0] out_rgb,
  // Status
  input wire [31:0] bitmap_line_addr,
  input wire overlay_on,
  input wire region_active
);
  reg [3:0] word_cnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Words taken in one burst; a gap in the request starts a new header
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      word_cnt <= 4'h0;
    else if (!mem_rd_req)
      word_cnt <= 4'h0;
    else if (mem_rd_valid && word_cnt != 4'hF)
      word_cnt <= word_cnt + 4'h1;
  end
  AST_REQ_HOLD: assert property (overlay_enable && mem_rd_req && !mem_rd_valid |=>
    mem_rd_req && $stable(mem_rd_addr)) else $error("read request moved before its answer");
  AST_HDR_STEP: assert property (overlay_enable && mem_rd_req && mem_rd_valid &&
    word_cnt < 4'h8 |=> mem_rd_req && mem_rd_addr == $past(mem_rd_addr) + 32'h4)
    else $error("header words not read at consecutive addresses");
  AST_OUT_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_rgb))
    else $error("stalled output word changed or vanished");
  AST_ONE_CYCLE: assert property (pix_valid && pix_ready && !out_valid |=> out_valid)
    else $error("accepted pixel not presented one cycle later");
  AST_REFUSE_FULL: assert property (!pix_ready |-> out_valid)
    else $error("pixel refused while nothing is buffered");
  AST_ACTIVE_LINE: assert property (overlay_enable && !line_start && !frame_start |=>
    $stable(region_active)) else $error("region flag changed without a line start");
  AST_ADDR_LINE: assert property (overlay_enable && !line_start && !frame_start |=>
    $stable(bitmap_line_addr)) else $error("line address changed without a line start");
  AST_ACTIVE_ON: assert property (region_active |-> overlay_on)
    else $error("region shown while overlay is off");
  AST_REQ_ON: assert property (mem_rd_req |-> overlay_on)
    else $error("descriptor read while overlay is off");
  AST_OFF: assert property (!overlay_enable |=> !mem_rd_req && !overlay_on)
    else $error("engine busy while disabled");
  cover property (mem_rd_req && mem_rd_valid && word_cnt == 4'h8);
  cover property (pix_valid && !pix_ready);
  cover property ($fell(overlay_on));
endmodule

bind orp_region_engine orp_props orp_props_inst (.clk_sys, .reset_n, .overlay_enable,
  .frame_start, .line_start, .mem_rd_req, .mem_rd_addr, .mem_rd_valid, .pix_valid,
  .pix_ready, .out_valid, .out_ready, .out_rgb, .bitmap_line_addr, .overlay_on,
  .region_active);

// ---- orp_mem_model.sv ----
/*
  Memory model answering the engine's word reads.
  Assumes word addresses below 400h; the answer delay is set by lat.
*/
`timescale 1ns/1ps
module orp_mem_model (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Read port
  input wire mem_rd_req,
  input wire [31:0] mem_rd_addr,
  output reg mem_rd_valid,
  output reg [31:0] mem_rd_data,
  // Answer delay in cycles
  input wire [3:0] lat
);
  reg [31:0] mem [0:255];
  reg [3:0] wait_cnt;
  // One word per request, the first after lat idle cycles and each later one after lat+1; between answers the bus
  // toggles so a stale word is never mistaken for a fresh one
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mem_rd_valid <= 1'h0;
      mem_rd_data <= 32'h0;
      wait_cnt <= 4'h0;
    end
    else if (mem_rd_req && !mem_rd_valid && wait_cnt >= lat)
    begin
      mem_rd_valid <= 1'h1;
      mem_rd_data <= mem[mem_rd_addr[9:2]];
      wait_cnt <= 4'h0;
    end
    else
    begin
      mem_rd_valid <= 1'h0;
      mem_rd_data <= ~mem_rd_data;
      if (mem_rd_req && !mem_rd_valid)
        wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// ---- test_osd_region_header_pixel_path.sv ----
/*
  Testbench of the overlay region engine with a two-region chain.
  Assumes orp_region_engine, orp_mem_model and the bound checker.
*/
`timescale 1ns/1ps
module test_osd_region_header_pixel_path;
  reg clk_sys, reset_n, overlay_enable, edge_smoothing_disable, frame_start, line_start;
  reg field_bottom, pix_valid, out_ready;
  reg [31:0] first_descriptor_addr;
  reg [7:0] edge_smoothing_value, pix_index;
  reg [10:0] line_number;
  reg [11:0] pix_x;
  reg [29:0] pix_video;
  reg [3:0] lat;
  reg [31:0] img [0:19];
  reg [31:0] taken [$];
  wire mem_rd_req, mem_rd_valid, pix_ready, out_valid, overlay_on, region_active;
  wire [31:0] mem_rd_addr, mem_rd_data, bitmap_line_addr;
  wire [29:0] out_rgb;
  integer n_fail, n_compared, k;
  integer cyc = 0;

  orp_region_engine orp_region_engine_inst (.clk_sys, .reset_n, .overlay_enable,
    .first_descriptor_addr, .edge_smoothing_disable, .edge_smoothing_value, .mem_rd_req,
    .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .frame_start, .line_start, .line_number,
    .field_bottom, .bitmap_line_addr, .pix_valid, .pix_ready, .pix_index, .pix_x,
    .pix_video, .out_valid, .out_ready, .out_rgb, .overlay_on, .region_active);
  orp_mem_model orp_mem_model_inst (.clk_sys, .reset_n, .mem_rd_req, .mem_rd_addr,
    .mem_rd_valid, .mem_rd_data, .lat);

  // Clock and a hang guard
  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc = cyc + 1;
    if (cyc == 3000)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t: timeout", $time);
      close_out;
    end
  end
  // Record every address whose word was taken
  always @(posedge clk_sys)
    if (reset_n && mem_rd_req && mem_rd_valid)
      taken.push_back(mem_rd_addr);

  task chk(input [31:0] got, input [31:0] exp);
  begin
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // Table colour widened to 10 bits, then optional gain and offset
  function [9:0] ex(input [7:0] c, input [5:0] g, input [9:0] o, input en);
    reg [16:0] t;
  begin
    t = {7'h0, c, c[7:6]};
    if (en)
      t = ((t * g) >> 5) + o;
    ex = (t > 17'h3FF) ? 10'h3FF : t[9:0];
  end
  endfunction

  task close_out;
  begin
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  // Waits for a burst to finish, then checks every address taken
  task fetch(input [31:0] base, input [31:0] pal, input integer np);
    integer n;
  begin
    n = 0;
    while ((taken.size() < 9 + np || mem_rd_req) && n < 400)
    begin
      @(negedge clk_sys);
      n = n + 1;
    end
    chk(taken.size(), 9 + np);
    for (n = 0; n < taken.size(); n = n + 1)
      chk(taken[n], (n < 9) ? base + 4 * n : pal + 4 * (n - 9));
    taken.delete();
  end
  endtask

  task line(input [10:0] ln, input bot);
  begin
    line_start = 1'h1;
    line_number = ln;
    field_bottom = bot;
    @(negedge clk_sys);
    line_start = 1'h0;
  end
  endtask

  task send(input [7:0] idx, input [29:0] vid);
  begin
    pix_valid = 1'h1;
    pix_index = idx;
    pix_video = vid;
    @(negedge clk_sys);
  end
  endtask

  task test_reset;
  begin
    chk(mem_rd_req, 0);
    chk(overlay_on, 0);
    chk(region_active, 0);
    chk(out_valid, 0);
    chk(pix_ready, 1);
    $display("reset test done");
  end
  endtask

  // First region: fresh two-colour palette, no mixing, gain on, stalled output
  task test_region1;
  begin
    overlay_enable = 1'h1;
    frame_start = 1'h1;
    @(negedge clk_sys);
    frame_start = 1'h0;
    fetch(32'h100, 32'h148, 2);
    line(11'h4, 1'h0);
    chk(region_active, 1);
    chk(bitmap_line_addr, 32'h1000);
    line(11'h5, 1'h0);
    chk(bitmap_line_addr, 32'h1040);
    out_ready = 1'h0;
    send(8'h10, 30'h0);
    send(8'h11, 30'h0);
    pix_valid = 1'h0;
    @(negedge clk_sys);
    chk(pix_ready, 0);
    chk(out_rgb, {ex(8'h80, 6'h10, 10'h10, 1), ex(8'h40, 6'h10, 10'h10, 1),
      ex(8'h20, 6'h10, 10'h10, 1)});
    out_ready = 1'h1;
    @(negedge clk_sys);
    chk(out_valid, 1);
    chk(out_rgb, {ex(8'h00, 6'h10, 10'h10, 1), ex(8'hFF, 6'h10, 10'h10, 1),
      ex(8'h00, 6'h10, 10'h10, 1)});
    @(negedge clk_sys);
    chk(out_valid, 0);
    lat = 4'h5;
    line(11'h6, 1'h0);
    chk(region_active, 0);
    fetch(32'h124, 32'h0, 0);
    $display("first region test done");
  end
  endtask

  // Second region: old palette kept, global weight saturated, gain off, stop
  task test_region2;
  begin
    line(11'h8, 1'h1);
    chk(bitmap_line_addr, 32'h3000);
    line(11'h9, 1'h1);
    chk(region_active, 1);
    chk(bitmap_line_addr, 32'h3040);
    send(8'h10, 30'h3FFFFFFF);
    pix_valid = 1'h0;
    chk(out_valid, 1);
    chk(out_rgb, {ex(8'h80, 6'h0, 10'h0, 0), ex(8'h40, 6'h0, 10'h0, 0),
      ex(8'h20, 6'h0, 10'h0, 0)});
    @(negedge clk_sys);
    line(11'hB, 1'h1);
    chk(overlay_on, 0);
    chk(region_active, 0);
    $display("second region test done");
  end
  endtask

  // Restarts the chain at the second header with new words 0 and 4, then
  // shows one pixel on its first line, where edge smoothing applies
  task frame_at(input [31:0] w0, input [31:0] w4);
  begin
    orp_mem_model_inst.mem[73] = w0;
    orp_mem_model_inst.mem[77] = w4;
    first_descriptor_addr = 32'h124;
    frame_start = 1'h1;
    @(negedge clk_sys);
    frame_start = 1'h0;
    fetch(32'h124, 32'h0, 0);
    line(11'h8, 1'h0);
    chk(bitmap_line_addr, 32'h4000);
    send(8'h10, 30'h0);
    pix_valid = 1'h0;
    chk(out_valid, 1);
  end
  endtask

  // Pixel mixing: edge-halved alpha on the first line, anti-flicker on the next
  task test_pixel_mix;
  begin
    frame_at(32'h01200FFF, 32'h00008FFF);
    chk(out_rgb, {10'h101, 10'h080, 10'h040});
    @(negedge clk_sys);
    line(11'h9, 1'h0);
    send(8'h11, 30'h0);
    pix_valid = 1'h0;
    chk(out_valid, 1);
    chk(out_rgb, {ex(8'h40, 6'h0, 10'h0, 0), ex(8'h9F, 6'h0, 10'h0, 0),
      ex(8'h10, 6'h0, 10'h0, 0)});
    @(negedge clk_sys);
    line(11'hB, 1'h0);
    chk(overlay_on, 0);
    $display("pixel mixing test done");
  end
  endtask

  // Proportional mixing by division, then anti-flutter blended over white video
  task test_prop_mix;
  begin
    frame_at(32'h01500FFF, 32'h7F808FFF);
    chk(out_rgb, {10'h080, 10'h040, 10'h020});
    @(negedge clk_sys);
    line(11'h9, 1'h0);
    send(8'h11, 30'h3FFFFFFF);
    pix_valid = 1'h0;
    chk(out_valid, 1);
    chk(out_rgb, {10'h23F, 10'h39F, 10'h20F});
    @(negedge clk_sys);
    line(11'hB, 1'h0);
    chk(overlay_on, 0);
    $display("proportional mixing test done");
  end
  endtask

  // Main sequence
  initial
  begin
    {reset_n, overlay_enable, edge_smoothing_disable, frame_start, line_start} = 5'h0;
    {field_bottom, pix_valid, pix_index, line_number, pix_video} = 51'h0;
    out_ready = 1'h1;
    first_descriptor_addr = 32'h100;
    edge_smoothing_value = 8'h40;
    pix_x = 12'h010;
    lat = 4'h0;
    n_fail = 0;
    n_compared = 0;
    img = '{32'h009D0FFF, 32'h00400110, 32'h043FFFFF, 32'h00005000, 32'h00004FFF,
      32'h00002000, 32'h00001000, 32'h00000148, 32'h00000124, 32'h01080FFF,
      32'h00400000, 32'h003FFFFF, 32'hC000A000, 32'h00008FFF, 32'h00003000,
      32'h00004000, 32'h00000000, 32'h00000000, 32'h80402080, 32'h00FF0080};
    for (k = 0; k < 20; k = k + 1)
      orp_mem_model_inst.mem[64 + k] = img[k];
    repeat (3) @(negedge clk_sys);
    test_reset;
    reset_n = 1'h1;
    @(negedge clk_sys);
    test_region1;
    test_region2;
    test_pixel_mix;
    test_prop_mix;
    close_out;
  end
endmodule
